// [rtl/bpwm_core.sv]
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
module bpwm_core
  import bpwm_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register bus.
  input wire bpwm_pkg::bpwm_wb_req_t wb_req,
  output bpwm_pkg::bpwm_wb_rsp_t wb_rsp,
  // Bridge outputs.
  output bpwm_pkg::bpwm_pins_t pins
);

  // Whole state of the block.
  typedef struct packed {
    logic [7:0] duty_high_write_reg;
    logic [7:0] duty_active_buffer;
    logic [7:0] capture_pwm_control_reg;
    logic [7:0] period_limit_reg;
    logic [7:0] dead_band_control_reg;
    logic [2:0] timer_ctrl;
    logic [7:0] period_timer;
    logic [1:0] qph;
    logic [3:0] prescale_cnt;
    logic [1:0] duty_low_latch;
    logic pwm_raw;
    logic act_pwm;
    logic [1:0] act_arr;
    logic [1:0] act_pol;
    logic [6:0] dead_cnt;
    logic [6:0] dead_lim;
    logic [3:0] outs;
    logic [3:0] drive;
    logic ack;
    logic [31:0] rdat;
  } bpwm_state_t;

  bpwm_state_t st;
  bpwm_state_t next_st;

  logic [1:0] timer_prescale_select;
  logic [1:0] module_mode_field;
  logic [1:0] output_arrangement_field;
  logic [1:0] duty_low_bits;
  logic bridge_direction_bit;
  logic mode_pwm;
  logic timer_on;
  logic [3:0] ps_last;
  logic [1:0] sub_count;
  logic [9:0] next_pos;
  logic tick;
  logic at_limit;
  logic period_end;
  logic early_swap;
  logic dead_ok;
  logic bus_req;
  logic bus_wr;
  logic [3:0] steer;
  logic [3:0] pol_mask;

  // Decoded control fields.
  assign timer_prescale_select = st.timer_ctrl[TCTL_PS_LSB +: 2];
  assign timer_on = st.timer_ctrl[TCTL_ON_BIT];
  assign output_arrangement_field = st.capture_pwm_control_reg[CTL_ARR_LSB +: 2];
  assign bridge_direction_bit = output_arrangement_field[1];
  assign duty_low_bits = st.capture_pwm_control_reg[CTL_DCLO_LSB +: 2];
  assign module_mode_field = st.capture_pwm_control_reg[CTL_MODE_LSB + 2 +: 2];
  assign mode_pwm = (module_mode_field == MODE_PWM_HI);

  // Prescaler length and the two sub-count bits that extend the timer.
  always_comb
  begin
    case (timer_prescale_select)
      PS_DIV1:
      begin
        ps_last = PS_LAST1;
        sub_count = st.qph;
      end
      PS_DIV4:
      begin
        ps_last = PS_LAST4;
        sub_count = st.prescale_cnt[1:0];
      end
      default:
      begin
        ps_last = PS_LAST16;
        sub_count = st.prescale_cnt[3:2];
      end
    endcase
  end

  // Timer tick and period boundary events.
  assign tick = timer_on && (st.qph == QPH_LAST) && (st.prescale_cnt == ps_last);
  assign at_limit = (st.period_timer == st.period_limit_reg);
  assign period_end = tick && at_limit;
  // Extended count one clock ahead: every clock at prescale 1, else on each sub-count step.
  assign next_pos = {st.period_timer, sub_count} + {9'h000, (timer_prescale_select == PS_DIV1)
    || ((st.qph == QPH_LAST)
    && ((timer_prescale_select == PS_DIV4) || (st.prescale_cnt[1:0] == PS_LAST4[1:0])))};

  // The last timer count of a period in which the direction is to change.
  assign early_swap = timer_on && at_limit && st.act_pwm && st.act_arr[0]
    && output_arrangement_field[0] && mode_pwm
    && (bridge_direction_bit != st.act_arr[1]);
  // Dead band has expired since the last raw edge.
  assign dead_ok = (st.dead_cnt >= st.dead_lim);
  // Bus access decode: a write acts on the edge that ends the cycle.
  assign bus_req = wb_req.cyc && wb_req.stb;
  assign bus_wr = bus_req && wb_req.we && st.ack && wb_req.sel[0];
  // Steering of the raw signal onto the four outputs before polarity.
  always_comb
  begin
    steer = 4'h0;
    case (st.act_arr)
      ARR_SINGLE:
      begin
        steer[0] = st.pwm_raw;
      end
      ARR_HALF:
      begin
        steer[0] = st.pwm_raw && dead_ok;
        steer[1] = !st.pwm_raw && dead_ok;
      end
      ARR_FWD:
      begin
        steer[0] = 1'b1;
        steer[3] = st.pwm_raw;
      end
      default:
      begin
        steer[2] = 1'b1;
        steer[1] = st.pwm_raw;
      end
    endcase
    if (early_swap)
    begin
      steer[0] = !bridge_direction_bit;
      steer[2] = bridge_direction_bit;
      steer[1] = 1'b0;
      steer[3] = 1'b0;
    end
  end
  // Active-low pairs invert after steering.
  assign pol_mask = {st.act_pol[0], st.act_pol[1], st.act_pol[0], st.act_pol[1]};

  // Next-state logic for the whole block.
  always_comb
  begin
    next_st = st;
    next_st.ack = bus_req && !st.ack;
    // Read data is captured in the cycle before the answer.
    next_st.rdat = 32'h0000_0000;
    if (bus_req && !st.ack)
    begin
      case (wb_req.adr)
        OFS_DUTY_HIGH: next_st.rdat[7:0] = st.duty_high_write_reg;
        OFS_DUTY_ACTIVE: next_st.rdat[7:0] = st.duty_active_buffer;
        OFS_CONTROL: next_st.rdat[7:0] = st.capture_pwm_control_reg;
        OFS_PERIOD: next_st.rdat[7:0] = st.period_limit_reg;
        OFS_DEAD_BAND: next_st.rdat[7:0] = st.dead_band_control_reg;
        OFS_TIMER_CTRL: next_st.rdat[2:0] = st.timer_ctrl;
        OFS_TIMER: next_st.rdat[7:0] = st.period_timer;
        default: next_st.rdat = 32'h0000_0000;
      endcase
    end
    // Register writes.
    if (bus_wr)
    begin
      case (wb_req.adr)
        OFS_DUTY_HIGH: next_st.duty_high_write_reg = wb_req.dat[7:0];
        OFS_DUTY_ACTIVE:
        begin
          if (!mode_pwm)
          begin
            next_st.duty_active_buffer = wb_req.dat[7:0];
          end
        end
        OFS_CONTROL: next_st.capture_pwm_control_reg = wb_req.dat[7:0];
        OFS_PERIOD: next_st.period_limit_reg = wb_req.dat[7:0];
        OFS_DEAD_BAND: next_st.dead_band_control_reg = wb_req.dat[7:0];
        OFS_TIMER_CTRL: next_st.timer_ctrl = wb_req.dat[2:0];
        default: next_st.timer_ctrl = st.timer_ctrl;
      endcase
    end
    // Quarter-cycle phase and prescaler.
    next_st.qph = st.qph + 2'h1;
    if (!timer_on)
    begin
      next_st.prescale_cnt = 4'h0;
    end
    else if (st.qph == QPH_LAST)
    begin
      next_st.prescale_cnt = tick ? 4'h0 : st.prescale_cnt + 4'h1;
    end
    // Period timer and the double-buffered loads.
    if (period_end)
    begin
      next_st.period_timer = 8'h00;
      next_st.duty_active_buffer = st.duty_high_write_reg;
      next_st.duty_low_latch = duty_low_bits;
      next_st.act_pwm = mode_pwm;
      next_st.act_arr = output_arrangement_field;
      next_st.act_pol = st.capture_pwm_control_reg[CTL_MODE_LSB +: 2];
      next_st.pwm_raw = mode_pwm
        && ({st.duty_high_write_reg, duty_low_bits} != 10'h000);
    end
    else
    begin
      if (tick)
      begin
        next_st.period_timer = st.period_timer + 8'h01;
      end
      // Clearing one clock ahead keeps the high time at exactly the duty count.
      if ((next_pos == {st.duty_active_buffer, st.duty_low_latch})
        || ({st.period_timer, sub_count} == {st.duty_active_buffer, st.duty_low_latch}))
      begin
        next_st.pwm_raw = 1'b0;
      end
    end
    // Leaving PWM mode shuts the modulator down at once.
    if (!mode_pwm)
    begin
      next_st.act_pwm = 1'b0;
      next_st.pwm_raw = 1'b0;
    end
    // Dead-band counter restarts on each raw edge, counts instruction cycles.
    if (next_st.pwm_raw != st.pwm_raw)
    begin
      next_st.dead_cnt = 7'h00;
      next_st.dead_lim = st.dead_band_control_reg[6:0];
    end
    else if ((st.qph == QPH_LAST) && (st.dead_cnt != DEAD_MAX))
    begin
      next_st.dead_cnt = st.dead_cnt + 7'h01;
    end
    // Output levels and pin ownership.
    if (st.act_pwm)
    begin
      next_st.outs = steer ^ pol_mask;
      case (st.act_arr)
        ARR_SINGLE: next_st.drive = 4'h1;
        ARR_HALF: next_st.drive = 4'h3;
        default: next_st.drive = 4'hF;
      endcase
    end
    else
    begin
      next_st.outs = 4'h0;
      next_st.drive = 4'h0;
    end
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= '0;
      st.duty_high_write_reg <= RST_DUTY_HIGH;
      st.capture_pwm_control_reg <= RST_CONTROL;
      st.period_limit_reg <= RST_PERIOD;
      st.dead_band_control_reg <= RST_DEAD_BAND;
      st.timer_ctrl <= RST_TIMER_CTRL;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register.
  assign wb_rsp.ack = st.ack;
  assign wb_rsp.dat = st.rdat;
  assign pins.level = st.outs;
  assign pins.drive = st.drive;

  // The active buffer takes the written duty at each period boundary.
  property p_duty_load;
    @(posedge clk) disable iff (rst)
    period_end |=> (st.duty_active_buffer == $past(st.duty_high_write_reg));
  endproperty
  a_duty_load: assert property (p_duty_load) else $error("duty buffer not loaded");

  // The active buffer does not follow bus writes in PWM mode.
  property p_buffer_ro;
    @(posedge clk) disable iff (rst)
    (bus_wr && (wb_req.adr == OFS_DUTY_ACTIVE) && mode_pwm && !period_end)
      |=> $stable(st.duty_active_buffer);
  endproperty
  a_buffer_ro: assert property (p_buffer_ro) else $error("active buffer written");

  // A match of the extended timer with the duty clears the raw signal.
  property p_clear_match;
    @(posedge clk) disable iff (rst)
    (st.pwm_raw && !period_end
      && ({st.period_timer, sub_count} == {st.duty_active_buffer, st.duty_low_latch}))
      |=> !st.pwm_raw;
  endproperty
  a_clear_match: assert property (p_clear_match) else $error("no clear on match");

  // Timer restarts and the raw signal rises on a nonzero duty.
  property p_period_wrap;
    @(posedge clk) disable iff (rst)
    (period_end && mode_pwm && ({st.duty_high_write_reg, duty_low_bits} != 10'h000))
      |=> (st.period_timer == 8'h00) && st.pwm_raw;
  endproperty
  a_period_wrap: assert property (p_period_wrap) else $error("period wrap wrong");

  // Half-bridge outputs stay inactive until the dead band expires.
  property p_dead_band;
    @(posedge clk) disable iff (rst)
    (st.act_pwm && (st.act_arr == ARR_HALF) && !dead_ok && !period_end)
      |=> (st.outs[0] == st.act_pol[1]) && (st.outs[1] == st.act_pol[0]);
  endproperty
  a_dead_band: assert property (p_dead_band) else $error("dead band violated");

  // Forward bridge holds A active and C inactive outside the early swap.
  property p_forward;
    @(posedge clk) disable iff (rst)
    (st.act_pwm && (st.act_arr == ARR_FWD) && !early_swap && !period_end)
      |=> (st.outs[0] != st.act_pol[1]) && (st.outs[2] == st.act_pol[1]);
  endproperty
  a_forward: assert property (p_forward) else $error("forward steering wrong");

  // During the early swap both modulated outputs are inactive.
  property p_early_swap;
    @(posedge clk) disable iff (rst)
    (early_swap && !period_end)
      |=> (st.outs[1] == st.act_pol[0]) && (st.outs[3] == st.act_pol[0]);
  endproperty
  a_early_swap: assert property (p_early_swap) else $error("B or D active in swap");

  // The active arrangement changes only at a period boundary.
  property p_deferred;
    @(posedge clk) disable iff (rst)
    (!period_end && mode_pwm) |=> $stable(st.act_arr);
  endproperty
  a_deferred: assert property (p_deferred) else $error("arrangement changed early");

  // Without PWM mode no pin is owned two cycles later.
  property p_release;
    @(posedge clk) disable iff (rst)
    !mode_pwm |=> ##1 (st.drive == 4'h0);
  endproperty
  a_release: assert property (p_release) else $error("pins not released");

endmodule

// [rtl/bpwm_pkg.sv]
package bpwm_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_DUTY_HIGH = 8'h00;
  localparam logic [7:0] OFS_DUTY_ACTIVE = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_PERIOD = 8'h0C;
  localparam logic [7:0] OFS_DEAD_BAND = 8'h10;
  localparam logic [7:0] OFS_TIMER_CTRL = 8'h14;
  localparam logic [7:0] OFS_TIMER = 8'h18;

  // Reset values of the software registers.
  localparam logic [7:0] RST_DUTY_HIGH = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'h00;
  localparam logic [7:0] RST_DEAD_BAND = 8'h00;
  localparam logic [2:0] RST_TIMER_CTRL = 3'h0;

  // Field positions in the control register.
  localparam int CTL_ARR_LSB = 6;
  localparam int CTL_DCLO_LSB = 4;
  localparam int CTL_MODE_LSB = 0;
  // Field positions in the timer control register.
  localparam int TCTL_PS_LSB = 0;
  localparam int TCTL_ON_BIT = 2;

  // Output arrangements.
  localparam logic [1:0] ARR_SINGLE = 2'h0;
  localparam logic [1:0] ARR_FWD = 2'h1;
  localparam logic [1:0] ARR_HALF = 2'h2;
  localparam logic [1:0] ARR_REV = 2'h3;

  // Upper two mode bits that select modulation.
  localparam logic [1:0] MODE_PWM_HI = 2'h3;

  // Prescale selections and the last prescaler count of each.
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV4 = 2'h1;
  localparam logic [3:0] PS_LAST1 = 4'h0;
  localparam logic [3:0] PS_LAST4 = 4'h3;
  localparam logic [3:0] PS_LAST16 = 4'hF;

  // Timing: one instruction cycle is four oscillator clocks.
  localparam int TOSC_NS = 5;
  localparam int TCY_NS = 4 * TOSC_NS;
  localparam int TCY_CLOCKS = TCY_NS / TOSC_NS;
  localparam logic [1:0] QPH_LAST = 2'(TCY_CLOCKS - 1);
  localparam logic [6:0] DEAD_MAX = 7'h7F;

  // Classic bus request from the master.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } bpwm_wb_req_t;

  // Classic bus answer to the master.
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } bpwm_wb_rsp_t;

  // Bridge pins: level and ownership (1 = block drives the pin).
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] drive;
  } bpwm_pins_t;

endpackage

// [tb/bpwm_bridge_model.sv]
`timescale 1ns/1ps
// Bridge switch drivers: counts conducting cycles of each switch and leg overlaps.
module bpwm_bridge_model
  import bpwm_pkg::*;
(
  // Clock and measurement clear.
  input wire logic clk,
  input wire logic clr,
  // Bridge pins from the block.
  input wire bpwm_pkg::bpwm_pins_t pins,
  // Measured figures.
  output logic [3:0][15:0] hi_cnt,
  output logic [15:0] shoot_cnt
);
  logic [3:0] on;

  // A switch conducts only while its pin is owned by the block and high.
  assign on = pins.level & pins.drive;

  // Legs are A over B and C over D, so both switches of a leg on means shoot-through.
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      hi_cnt[i] <= clr ? 16'h0000 : hi_cnt[i] + 16'(on[i]);
    end
    shoot_cnt <= clr ? 16'h0000 : shoot_cnt + 16'((on[0] & on[1]) | (on[2] & on[3]));
  end
endmodule

// [tb/bridge_pwm_output_steering_tb.sv]
`timescale 1ns/1ps
module bridge_pwm_output_steering_tb;
  import bpwm_pkg::*;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end

  logic clk;
  logic rst;
  logic clr;
  bpwm_wb_req_t req;
  bpwm_wb_rsp_t rsp;
  bpwm_pins_t pins;
  logic [3:0][15:0] hi_cnt;
  logic [15:0] shoot_cnt;
  logic [7:0] rd;
  logic [7:0] ofs [8];
  logic [9:0] dv [3];
  logic [1:0] arr;
  int ex [3];
  int fail_count;
  int n_compared;
  int cycles;
  int per;
  int a, b, c, d;

  bpwm_core bpwm_core_i (.clk(clk), .rst(rst), .wb_req(req), .wb_rsp(rsp), .pins(pins));
  bpwm_bridge_model bpwm_bridge_model_i (.clk(clk), .clr(clr), .pins(pins), .hi_cnt(hi_cnt),
    .shoot_cnt(shoot_cnt));

  // Clock of 5 ns period.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cuts a hang short.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fail_count++;
      complete_run();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("Compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One classic bus cycle; read data lands in rd at the acknowledging edge.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h00_0000, dat}};
    do
    begin
      @(posedge clk);
    end
    while (rsp.ack !== 1'b1);
    `CHK("ack", 1'b1, rsp.ack)
    rd = rsp.dat[7:0];
    req <= '0;
  endtask

  // Programs every field, starts the timer and lets the settings reach a period boundary.
  task automatic cfg(input logic [1:0] ar, input logic [3:0] mode, input logic [9:0] duty,
    input logic [7:0] lim, input logic [1:0] ps, input logic [6:0] db);
    wb(1'b1, OFS_DEAD_BAND, {1'b0, db});
    wb(1'b1, OFS_PERIOD, lim);
    wb(1'b1, OFS_DUTY_HIGH, duty[9:2]);
    wb(1'b1, OFS_CONTROL, {ar, duty[1:0], mode});
    wb(1'b1, OFS_TIMER_CTRL, {5'h00, 1'b1, ps});
    per = 4 * (int'(lim) + 1) * (ps == PS_DIV1 ? 1 : (ps == PS_DIV4 ? 4 : 16));
    repeat (3 * per + 8) @(posedge clk);
  endtask

  // Measures four periods of switch activity.
  task automatic meas();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (4 * per) @(posedge clk);
    #1;
  endtask

  // Compares the four switch counts.
  task automatic chk4(input int e0, input int e1, input int e2, input int e3);
    int e [4];
    e = '{e0, e1, e2, e3};
    for (int i = 0; i < 4; i++)
      `CHK("switch count", 16'(e[i]), hi_cnt[i])
  endtask

  // Main sequence.
  initial
  begin
    rst = 1'b1;
    clr = 1'b0;
    req = '0;
    fail_count = 0;
    n_compared = 0;
    cycles = 0;
    per = 4;
    ofs = '{OFS_DUTY_HIGH, OFS_DUTY_ACTIVE, OFS_CONTROL, OFS_PERIOD, OFS_DEAD_BAND,
      OFS_TIMER_CTRL, OFS_TIMER, 8'h1C};
    dv = '{10'h000, 10'h002, 10'h3FF};
    ex = '{0, 2, 4};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // A write to an unmapped place, then the reset values.
    wb(1'b1, 8'h1C, 8'h5A);
    for (int i = 0; i < 8; i++)
    begin
      wb(1'b0, ofs[i], 8'h00);
      `CHK("reset read", 8'h00, rd)
    end
    `CHK("drive", 4'h0, pins.drive)
    $display("Test reset done");
    // Single output: zero, mid and over-long duty.
    for (int i = 0; i < 3; i++)
    begin
      cfg(ARR_SINGLE, 4'hC, dv[i], 8'h00, PS_DIV1, 7'h00);
      meas();
      chk4(ex[i] * 4, 0, 0, 0);
    end
    `CHK("drive", 4'h1, pins.drive)
    // Prescaled timer keeps the duty at half the period.
    cfg(ARR_SINGLE, 4'hC, 10'h002, 8'h00, PS_DIV4, 7'h00);
    meas();
    chk4(per * 2, 0, 0, 0);
    cfg(ARR_SINGLE, 4'hC, 10'h002, 8'h00, 2'h2, 7'h00);
    meas();
    chk4(per * 2, 0, 0, 0);
    $display("Test single done");
    // Half bridge with a dead band of one, then one longer than either phase.
    cfg(ARR_HALF, 4'hC, 10'h008, 8'h03, PS_DIV1, 7'h01);
    meas();
    chk4(16, 16, 0, 0);
    `CHK("drive", 4'h3, pins.drive)
    `CHK("shoot", 16'h0000, shoot_cnt)
    cfg(ARR_HALF, 4'hC, 10'h008, 8'h03, PS_DIV1, 7'h05);
    meas();
    chk4(0, 0, 0, 0);
    $display("Test half bridge done");
    // Full bridge, both directions under every polarity, with a dead band set.
    for (int m = 0; m < 4; m++)
    begin
      for (int r = 0; r < 2; r++)
      begin
        arr = r[0] ? ARR_REV : ARR_FWD;
        cfg(arr, 4'hC | 4'(m), 10'h008, 8'h03, PS_DIV1, 7'h03);
        meas();
        a = r[0] ? 0 : 4 * per;
        c = 4 * per - a;
        d = r[0] ? 0 : 2 * per;
        b = 2 * per - d;
        if (m[1])
        begin
          a = 4 * per - a;
          c = 4 * per - c;
        end
        if (m[0])
        begin
          b = 4 * per - b;
          d = 4 * per - d;
        end
        chk4(a, b, c, d);
        `CHK("drive", 4'hF, pins.drive)
      end
    end
    // Direction flip while running: no leg may conduct top and bottom at once.
    cfg(ARR_FWD, 4'hC, 10'h008, 8'h03, PS_DIV1, 7'h00);
    wb(1'b1, OFS_CONTROL, {ARR_REV, 2'b00, 4'hC});
    meas();
    `CHK("shoot", 16'h0000, shoot_cnt)
    meas();
    chk4(0, 2 * per, 4 * per, 0);
    $display("Test full bridge done");
    // Duty buffering on a long period.
    cfg(ARR_SINGLE, 4'hC, 10'h100, 8'hFF, PS_DIV1, 7'h00);
    wb(1'b0, OFS_DUTY_ACTIVE, 8'h00);
    `CHK("active duty", 8'h40, rd)
    wb(1'b1, OFS_DUTY_ACTIVE, 8'hAA);
    wb(1'b0, OFS_DUTY_ACTIVE, 8'h00);
    `CHK("active duty", 8'h40, rd)
    wb(1'b1, OFS_DUTY_HIGH, 8'h55);
    wb(1'b0, OFS_DUTY_ACTIVE, 8'h00);
    `CHK("active duty", 8'h40, rd)
    repeat (per + 8) @(posedge clk);
    wb(1'b0, OFS_DUTY_ACTIVE, 8'h00);
    `CHK("active duty", 8'h55, rd)
    $display("Test duty buffer done");
    complete_run();
  end
endmodule
